//--- src/dbc_pkg.sv
// Purpose: Shared constants and types for the DRAM and bus controller.
// Assumes: One 100 MHz clock, synchronous active-high reset.
// Notes:   Address decode values and timing counts live here only.
package dbc_pkg;
    // Clock period in nanoseconds.
    localparam int unsigned CLK_NS       = 10;
    // Refresh request interval in nanoseconds and its cycle count (rounded down).
    localparam int unsigned REF_NS       = 15600;
    localparam int unsigned REF_CYC      = REF_NS / CLK_NS;
    localparam logic [10:0] REF_LAST     = 11'(REF_CYC - 1);
    // Last count of the processor reset stretch after the system reset is released; the stretch lasts 16 cycles.
    localparam logic [3:0]  RST_HOLD     = 4'hF;
    // Memory size selections for the fitted modules.
    localparam logic [2:0]  SZ_1MB       = 3'h0;
    localparam logic [2:0]  SZ_2MB       = 3'h1;
    localparam logic [2:0]  SZ_4MB       = 3'h2;
    localparam logic [2:0]  SZ_8MB       = 3'h3;
    localparam logic [2:0]  SZ_16MB      = 3'h4;
    // Flash occupies the top two megabytes of the address space.
    localparam logic [4:0]  FLASH_TOP    = 5'h1F;
    // I/O decode of the on-board peripherals.
    localparam logic [15:0] IO_RTC_IDX   = 16'h0070;
    localparam logic [15:0] IO_RTC_DAT   = 16'h0071;
    localparam logic [15:0] IO_KBC_DAT   = 16'h0060;
    localparam logic [15:0] IO_KBC_CMD   = 16'h0064;
    localparam logic [12:0] IO_IDE_BASE  = 13'h003E;
    // Select bit positions in the chip select vector.
    localparam int unsigned CS_FLASH     = 0;
    localparam int unsigned CS_RTC       = 1;
    localparam int unsigned CS_IDE       = 2;
    localparam int unsigned CS_KBC       = 3;

    // Sequencer states.
    typedef enum logic [3:0] {
        ST_IDLE    = 4'h0,
        ST_ROW     = 4'h1,
        ST_COL     = 4'h2,
        ST_PRE     = 4'h3,
        ST_REF_CAS = 4'h4,
        ST_REF_RAS = 4'h5,
        ST_REF_END = 4'h6,
        ST_EXT_ALE = 4'h7,
        ST_EXT_CMD = 4'h8,
        ST_EXT_END = 4'h9,
        ST_RST     = 4'hA
    } dbc_state_t;
endpackage : dbc_pkg

//--- src/dbc_ctrl.sv
// Purpose: DRAM, reset, ready and expansion bus controller for a 32-bit embedded processor.
// Assumes: Processor address is held stable from address strobe until ready.
// Notes:   Configuration inputs are straps sampled continuously; change them only in reset.
// What this block does
// - Zero-wait fast page reads and writes on hits.
// - Mux row/column, drive strobes, CAS-before-RAS refresh.
// - Row/column widths follow 1 to 16 MB modules.
// - Two banks interleave, controller picks the bank.
// - Two banks, FPM or EDO, configurable start.
// - Periodic refresh requests with refresh row address.
// - Processor reset synchronised to processor clock.
// - Ready for non-local cycles after target completes.
// - I/O and memory strobes plus address latch.
// - Own data buffer enable avoids bus contention.
// - Selects for flash, clock, disk, keyboard.
// - No parity generated or checked.
module dbc_ctrl
    import dbc_pkg::*;
(
    // Clock and reset.
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // Processor bus.
    input  wire logic        cpu_ads_n,
    input  wire logic [25:1] cpu_addr,
    input  wire logic        cpu_wr,
    input  wire logic        cpu_mio,
    input  wire logic        cpu_local_n,
    output logic             cpu_ready_n,
    output logic             cpu_reset,
    // Configuration straps.
    input  wire logic [2:0]  cfg_size,
    input  wire logic        cfg_two_banks,
    input  wire logic        cfg_interleave,
    input  wire logic [4:0]  cfg_bank1_mb,
    input  wire logic        cfg_edo,
    // DRAM.
    output logic [11:0]      dram_addr,
    output logic [1:0]       dram_ras_n,
    output logic [1:0]       dram_cas_n,
    output logic             dram_we_n,
    // Expansion bus.
    input  wire logic        ext_rdy,
    output logic             ext_ale,
    output logic             ext_ior_n,
    output logic             ext_iow_n,
    output logic             ext_memr_n,
    output logic             ext_memw_n,
    output logic             dbuf_en_n,
    // Peripheral selects, active low.
    output logic [3:0]       per_cs_n
);
    import dbc_pkg::*;

    // Complete state of the block.
    typedef struct packed {
        dbc_state_t       state;
        logic [3:0]       rst_cnt;
        logic             cpu_reset;
        logic             ready_n;
        logic [10:0]      ref_cnt;
        logic             ref_pend;
        logic [11:0]      ref_row;
        logic             req_pend;
        logic             req_bank;
        logic [1:0]       open_vld;
        logic [1:0][11:0] open_row;
        logic [11:0]      addr;
        logic [1:0]       ras_n;
        logic [1:0]       cas_n;
        logic             we_n;
        logic             ale;
        logic             ior_n;
        logic             iow_n;
        logic             memr_n;
        logic             memw_n;
        logic             dbuf_n;
        logic [3:0]       cs_n;
    } dbc_regs_t;

    dbc_regs_t st_reg;   // Registered state.
    dbc_regs_t st_next;  // Next state.

    // Column width in bits for each module size; the row takes the rest.
    function automatic logic [3:0] dbc_col_bits(input logic [2:0] sz);
        unique case (sz)
            SZ_1MB:  dbc_col_bits = 4'h9;
            SZ_2MB:  dbc_col_bits = 4'hA;
            SZ_4MB:  dbc_col_bits = 4'hA;
            SZ_8MB:  dbc_col_bits = 4'hB;
            default: dbc_col_bits = 4'hB;
        endcase
    endfunction : dbc_col_bits

    // Word address within the selected bank.
    function automatic logic [22:0] dbc_word(input logic [25:1] a, input logic bank1,
                                             input logic [4:0] start, input logic il);
        logic [23:0] off;
        off = (bank1 && !il) ? 24'(a[24:1] - {start, 19'h0}) : a[24:1];
        dbc_word = off[22:0];
    endfunction : dbc_word

    // Row and column of a word address for the configured size.
    function automatic logic [11:0] dbc_row(input logic [22:0] w, input logic [2:0] sz, input logic il);
        logic [22:0] r;
        r = w >> dbc_col_bits(sz);
        // When interleaving, the lowest row bit picks the bank and is dropped.
        dbc_row = il ? r[12:1] : r[11:0];
    endfunction : dbc_row

    function automatic logic [11:0] dbc_col(input logic [22:0] w, input logic [2:0] sz);
        logic [22:0] m;
        m = (23'h1 << dbc_col_bits(sz)) - 23'h1;
        dbc_col = 12'(w & m);
    endfunction : dbc_col

    // Address decode of the current request.
    logic        is_dram;   // Cycle targets on-board DRAM.
    logic        is_flash;  // Cycle targets the flash.
    logic        il;        // Interleaving is active.
    logic        bank;      // Bank targeted by the cycle.
    logic [22:0] word;      // Word address within that bank.
    logic [11:0] row;       // Row part of the address.
    logic [11:0] col;       // Column part of the address.
    logic        hit;       // Row already open in the target bank.
    logic        go;        // A request is present this cycle.
    logic [3:0]  sel_n;     // Peripheral selects for the request.

    // Bank, row and column steering; parity is neither generated nor checked.
    always_comb begin
        il       = cfg_two_banks && cfg_interleave;
        is_flash = cpu_mio && (cpu_addr[25:21] == FLASH_TOP);
        is_dram  = cpu_mio && !cpu_addr[25] && cpu_local_n;
        if (!cfg_two_banks) begin
            bank = 1'b0;
        end else if (il) begin
            bank = cpu_addr[dbc_col_bits(cfg_size) + 5'h1];
        end else begin
            bank = (cpu_addr[24:20] >= cfg_bank1_mb);
        end
        word  = dbc_word(cpu_addr, bank, cfg_bank1_mb, il);
        row   = dbc_row(word, cfg_size, il);
        col   = dbc_col(word, cfg_size);
        hit   = st_reg.open_vld[bank] && (st_reg.open_row[bank] == row);
        go    = !cpu_ads_n || st_reg.req_pend;
        sel_n = 4'hF;
        sel_n[CS_FLASH] = !is_flash;
        if (!cpu_mio) begin
            sel_n[CS_RTC] = !(cpu_addr[15:1] == IO_RTC_IDX[15:1]) || (IO_RTC_DAT[15:1] != IO_RTC_IDX[15:1]);
            sel_n[CS_KBC] = !((cpu_addr[15:1] == IO_KBC_DAT[15:1]) || (cpu_addr[15:1] == IO_KBC_CMD[15:1]));
            sel_n[CS_IDE] = !(cpu_addr[15:3] == IO_IDE_BASE);
        end
    end

    // Next-state logic for the whole block.
    always_comb begin
        st_next         = st_reg;
        st_next.ready_n = 1'b1;
        st_next.ale     = 1'b0;
        // Refresh interval timer raises a request; ST_REF_RAS steps the refresh row.
        if (st_reg.ref_cnt == REF_LAST) begin
            st_next.ref_cnt  = 11'h0;
            st_next.ref_pend = 1'b1;
        end else begin
            st_next.ref_cnt = st_reg.ref_cnt + 11'h1;
        end
        // A strobe seen while busy is remembered until it can be served.
        if (!cpu_ads_n) begin
            st_next.req_pend = 1'b1;
        end
        unique case (st_reg.state)
            // Hold the processor in reset for a fixed count after release.
            ST_RST: begin
                st_next.cpu_reset = 1'b1;
                st_next.rst_cnt   = st_reg.rst_cnt + 4'h1;
                if (st_reg.rst_cnt == RST_HOLD) begin
                    st_next.cpu_reset = 1'b0;
                    st_next.state     = ST_IDLE;
                end
            end
            // Pick refresh first, then DRAM, then the expansion side.
            ST_IDLE: begin
                st_next.cas_n  = 2'h3;
                st_next.we_n   = 1'b1;
                st_next.dbuf_n = 1'b1;
                if (st_reg.ref_pend) begin
                    st_next.ras_n    = 2'h3;
                    st_next.open_vld = 2'h0;
                    st_next.state    = ST_PRE;
                end else if (go && !cpu_local_n) begin
                    st_next.req_pend = 1'b0;  // Local devices answer for themselves.
                end else if (go && is_dram) begin
                    st_next.req_pend = 1'b0;
                    st_next.req_bank = bank;
                    if (hit) begin
                        st_next.addr            = col;
                        st_next.cas_n[bank]     = 1'b0;
                        st_next.we_n            = !cpu_wr;
                        st_next.dbuf_n          = 1'b0;
                        st_next.ready_n         = 1'b0;
                        st_next.state           = ST_COL;
                    end else if (st_reg.open_vld[bank]) begin
                        // Another row is open in this bank: raise its row strobe for one cycle of
                        // precharge and keep the request pending, so the row phase follows next.
                        st_next.req_pend        = 1'b1;
                        st_next.ras_n[bank]     = 1'b1;
                        st_next.open_vld[bank]  = 1'b0;
                    end else begin
                        st_next.addr            = row;
                        st_next.ras_n[bank]     = 1'b0;
                        st_next.open_row[bank]  = row;
                        st_next.open_vld[bank]  = 1'b1;
                        st_next.state           = ST_ROW;
                    end
                end else if (go) begin
                    st_next.req_pend = 1'b0;
                    st_next.ale      = 1'b1;
                    st_next.cs_n     = sel_n;
                    st_next.state    = ST_EXT_ALE;
                end
            end
            // Row open: present the column and finish in one cycle.
            ST_ROW: begin
                st_next.addr                 = col;
                st_next.cas_n[st_reg.req_bank] = 1'b0;
                st_next.we_n                 = !cpu_wr;
                st_next.dbuf_n               = 1'b0;
                st_next.ready_n              = 1'b0;
                st_next.state                = ST_COL;
            end
            // Column strobe ends; the page stays open for the next hit.
            ST_COL: begin
                st_next.cas_n  = 2'h3;
                st_next.we_n   = 1'b1;
                st_next.dbuf_n = 1'b1;
                // EDO parts keep data after CAS rises, FPM parts drop it; both close here.
                st_next.state  = ST_IDLE;
            end
            // Precharge before refresh with all row strobes high.
            ST_PRE: begin
                st_next.addr  = st_reg.ref_row;
                st_next.state = ST_REF_CAS;
                st_next.cas_n = 2'h0;
            end
            // Column strobe already low; now drop row strobe.
            ST_REF_CAS: begin
                st_next.ras_n = 2'h0;
                st_next.state = ST_REF_RAS;
            end
            // Release both strobes and advance the refresh row.
            ST_REF_RAS: begin
                st_next.ras_n    = 2'h3;
                st_next.cas_n    = 2'h3;
                st_next.ref_pend = (st_reg.ref_cnt == REF_LAST);
                st_next.ref_row  = st_reg.ref_row + 12'h1;
                st_next.state    = ST_REF_END;
            end
            // One cycle of precharge before anything else starts.
            ST_REF_END: begin
                st_next.state = ST_IDLE;
            end
            // Address latched; assert the command strobe and buffer.
            ST_EXT_ALE: begin
                st_next.ior_n  = !(!cpu_mio && !cpu_wr);
                st_next.iow_n  = !(!cpu_mio && cpu_wr);
                st_next.memr_n = !(cpu_mio && !cpu_wr);
                st_next.memw_n = !(cpu_mio && cpu_wr);
                st_next.dbuf_n = 1'b0;
                st_next.state  = ST_EXT_CMD;
            end
            // Wait for the target, then answer the processor.
            ST_EXT_CMD: begin
                if (ext_rdy) begin
                    st_next.ready_n = 1'b0;
                    st_next.state   = ST_EXT_END;
                end
            end
            // Strobes, buffer and selects release together.
            ST_EXT_END: begin
                st_next.ior_n  = 1'b1;
                st_next.iow_n  = 1'b1;
                st_next.memr_n = 1'b1;
                st_next.memw_n = 1'b1;
                st_next.dbuf_n = 1'b1;
                st_next.cs_n   = 4'hF;
                st_next.state  = ST_IDLE;
            end
            default: begin
                st_next.state = ST_IDLE;
            end
        endcase
        // Cycle strobes taken in the completing cycle are not new requests.
        if (!st_next.ready_n) begin
            st_next.req_pend = 1'b0;
        end
    end

    // State register; reset closes every page and parks all strobes.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_reg           <= '0;
            st_reg.state     <= ST_RST;
            st_reg.cpu_reset <= 1'b1;
            st_reg.ready_n   <= 1'b1;
            st_reg.ras_n     <= 2'h3;
            st_reg.cas_n     <= 2'h3;
            st_reg.we_n      <= 1'b1;
            st_reg.ior_n     <= 1'b1;
            st_reg.iow_n     <= 1'b1;
            st_reg.memr_n    <= 1'b1;
            st_reg.memw_n    <= 1'b1;
            st_reg.dbuf_n    <= 1'b1;
            st_reg.cs_n      <= 4'hF;
        end else begin
            st_reg <= st_next;
        end
    end

    // All outputs come straight from the state register.
    assign cpu_ready_n = st_reg.ready_n;
    assign cpu_reset   = st_reg.cpu_reset;
    assign dram_addr   = st_reg.addr;
    assign dram_ras_n  = st_reg.ras_n;
    assign dram_cas_n  = st_reg.cas_n;
    assign dram_we_n   = st_reg.we_n;
    assign ext_ale     = st_reg.ale;
    assign ext_ior_n   = st_reg.ior_n;
    assign ext_iow_n   = st_reg.iow_n;
    assign ext_memr_n  = st_reg.memr_n;
    assign ext_memw_n  = st_reg.memw_n;
    assign dbuf_en_n   = st_reg.dbuf_n;
    assign per_cs_n    = st_reg.cs_n;
endmodule : dbc_ctrl

//--- verif/dbc_chk.sv
// Purpose: Port checks for the DRAM and bus controller.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Attached to every controller by the bind below.
module dbc_chk
    import dbc_pkg::*;
(
    // Clock, reset and watched signals.
    input wire logic       sys_clk,
    input wire logic       rst,
    input wire logic       cpu_ready_n,
    input wire logic       cpu_reset,
    input wire logic [1:0] dram_ras_n,
    input wire logic [1:0] dram_cas_n,
    input wire logic       ext_rdy,
    input wire logic       ext_ale,
    input wire logic       ext_ior_n,
    input wire logic       ext_iow_n,
    input wire logic       ext_memr_n,
    input wire logic       ext_memw_n,
    input wire logic       dbuf_en_n,
    input wire logic [3:0] per_cs_n
);
    timeunit 1ns;
    timeprecision 1ns;
    // Cycles since reset release, saturating at 31.
    logic [4:0] since_reg;
    // High while any command strobe is active.
    logic       cmd;
    assign cmd = !(ext_ior_n && ext_iow_n && ext_memr_n && ext_memw_n);
    always_ff @(posedge sys_clk) begin
        if (rst) since_reg <= 5'h00;
        else if (since_reg != 5'h1F) since_reg <= since_reg + 5'h01;
    end
    default clocking dc @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_ready_pulse: assert property (!cpu_ready_n |=> cpu_ready_n)
        else $error("Ready held over one cycle.");
    a_reset_hold: assert property (since_reg < 5'h0F |-> cpu_reset)
        else $error("Processor reset dropped early.");
    a_reset_drop: assert property (since_reg == 5'h1F |-> !cpu_reset)
        else $error("Processor reset stuck high.");
    a_cbr_order: assert property (dram_ras_n == 2'b00 && $past(dram_ras_n) == 2'b11 |-> $past(dram_cas_n) == 2'b00)
        else $error("Refresh row strobe before column strobe.");
    a_ref_hold: assert property (dram_cas_n == 2'b00 |-> cpu_ready_n)
        else $error("Ready during refresh.");
    a_cas_ready: assert property (dram_cas_n inside {2'b01, 2'b10} |-> !cpu_ready_n && !dbuf_en_n)
        else $error("Access strobe without ready and buffer.");
    a_ext_wait: assert property (cmd && !ext_rdy && cpu_ready_n |=> cpu_ready_n)
        else $error("Ready before target done.");
    a_ext_done: assert property (cmd && ext_rdy && cpu_ready_n && $past(cpu_ready_n) |=> !cpu_ready_n)
        else $error("Ready late after target done.");
    a_ale_cmd: assert property (ext_ale |=> !ext_ale ##1 cmd)
        else $error("Latch pulse not followed by command.");
    a_one_sel: assert property ($onehot0({~ext_ior_n, ~ext_iow_n, ~ext_memr_n, ~ext_memw_n}) && $onehot0(~per_cs_n))
        else $error("Two strobes or selects at once.");
    // Main scenarios reached.
    c_refresh: cover property (dram_cas_n == 2'b00);
    c_io_ready: cover property (!cpu_ready_n && !ext_ior_n);
    c_reset_end: cover property ($fell(cpu_reset));
endmodule : dbc_chk

bind dbc_ctrl dbc_chk chk_u (.sys_clk, .rst, .cpu_ready_n, .cpu_reset, .dram_ras_n, .dram_cas_n, .ext_rdy,
    .ext_ale, .ext_ior_n, .ext_iow_n, .ext_memr_n, .ext_memw_n, .dbuf_en_n, .per_cs_n);

//--- verif/dbc_ext_tgt.sv
// Purpose: Expansion target that answers command strobes.
// Assumes: The controller samples ready on rising edges.
// Notes:   dly sets the busy cycles of each command.
module dbc_ext_tgt (
    // Clock and command strobes.
    input wire logic       sys_clk,
    input wire logic       ext_ior_n,
    input wire logic       ext_iow_n,
    input wire logic       ext_memr_n,
    input wire logic       ext_memw_n,
    // Busy time and completion.
    input wire logic [1:0] dly,
    output logic           ext_rdy
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] busy_reg;
    logic       act;
    assign act = !(ext_ior_n && ext_iow_n && ext_memr_n && ext_memw_n);
    // Count while a command stands; cleared between commands.
    always_ff @(posedge sys_clk) begin
        busy_reg <= act ? busy_reg + 3'h1 : 3'h0;
    end
    // Not ready between commands, so a stale level is never offered.
    assign ext_rdy = act && (busy_reg >= {1'b0, dly});
endmodule : dbc_ext_tgt

//--- verif/tb_top.sv
// Purpose: Self-checking bench for the DRAM and bus controller.
// Assumes: 100 MHz clock, reset held five cycles per setup.
// Notes:   DRAM traffic comes from a fixed-seed LFSR.
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import dbc_pkg::*;
    // Design inputs, all set at time zero.
    logic        sys_clk = 1'b0, rst = 1'b1, cpu_ads_n = 1'b1, cpu_wr = 1'b0, cpu_mio = 1'b1;
    logic        cpu_local_n = 1'b1, cfg_two_banks = 1'b0, cfg_interleave = 1'b0, cfg_edo = 1'b0;
    logic [25:1] cpu_addr = 25'h0000000;
    logic [2:0]  cfg_size = 3'h0;
    logic [4:0]  cfg_bank1_mb = 5'h01;
    logic [1:0]  dly = 2'h0;
    // Design outputs.
    logic        cpu_ready_n, cpu_reset, dram_we_n, ext_rdy, ext_ale, dbuf_en_n;
    logic        ext_ior_n, ext_iow_n, ext_memr_n, ext_memw_n;
    logic [11:0] dram_addr;
    logic [1:0]  dram_ras_n, dram_cas_n;
    logic [3:0]  per_cs_n;
    // Counters, random source and open-page model.
    int          mismatches = 0, total_checks = 0;
    logic [15:0] lfsr = 16'hE29F;
    logic [11:0] orow [2];
    logic        ovld [2];
    // Scenario tables: DRAM layouts, then expansion cycles with expected selects and strobes.
    logic [2:0]  szs [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h0};
    logic [5:0]  twos = 6'b101010, ils = 6'b001010;
    logic [25:1] xa [9] = '{25'h38, 25'h38, 25'h32, 25'h30, 25'hFA, 25'h1F00000, 25'h1F00000, 25'h180, 25'h1000000};
    logic [1:0]  xmw [9] = '{2'h0, 2'h1, 2'h1, 2'h0, 2'h0, 2'h2, 2'h3, 2'h0, 2'h3};
    logic [7:0]  xe [9] = '{8'hD7, 8'hDB, 8'h7B, 8'h77, 8'hB7, 8'hED, 8'hEE, 8'hF7, 8'hFE};
    always #5 sys_clk = ~sys_clk;
    dbc_ctrl dut_u (.sys_clk, .rst, .cpu_ads_n, .cpu_addr, .cpu_wr, .cpu_mio, .cpu_local_n, .cpu_ready_n,
        .cpu_reset, .cfg_size, .cfg_two_banks, .cfg_interleave, .cfg_bank1_mb, .cfg_edo, .dram_addr,
        .dram_ras_n, .dram_cas_n, .dram_we_n, .ext_rdy, .ext_ale, .ext_ior_n, .ext_iow_n, .ext_memr_n,
        .ext_memw_n, .dbuf_en_n, .per_cs_n);
    dbc_ext_tgt tgt_u (.sys_clk, .ext_ior_n, .ext_iow_n, .ext_memr_n, .ext_memw_n, .dly, .ext_rdy);
    // Next LFSR value.
    function automatic logic [15:0] step(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : step
    // Compare and count.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // Report and end the run.
    task automatic conclude();
        $display("checks=%0d mismatches=%0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude
    // Reset with new straps, then wait for the processor reset to end.
    task automatic reset_cfg(input logic [2:0] sz, input logic two, input logic il);
        int n;
        @(posedge sys_clk);
        rst <= 1'b1;
        cfg_size <= sz;
        cfg_two_banks <= two;
        cfg_interleave <= il;
        cfg_edo <= il;
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (cpu_reset !== 1'b0 && n < 40);
        check(32'(n >= 17 && n < 40), 32'h1);
        if (n >= 40) conclude();
        ovld = '{1'b0, 1'b0};
    endtask : reset_cfg
    // One processor cycle; returns at the negedge of the ready cycle.
    task automatic bus(input logic [25:1] a, input logic w, input logic m, input logic loc, input int gap,
                       output int lat, output logic [11:0] row, output logic al);
        repeat (gap) @(posedge sys_clk);
        @(posedge sys_clk);
        cpu_addr <= a;
        cpu_wr <= w;
        cpu_mio <= m;
        cpu_local_n <= loc;
        cpu_ads_n <= 1'b0;
        @(posedge sys_clk);
        cpu_ads_n <= 1'b1;
        lat = 0;
        do begin
            @(negedge sys_clk);
            lat++;
            if (cpu_ready_n !== 1'b0) row = dram_addr;
            if (lat == 1) al = ext_ale;
        end while (cpu_ready_n !== 1'b0 && lat < 12);
        if (lat >= 12 && loc) check(32'h0, 32'h1);
        if (lat >= 12 && loc) conclude();
    endtask : bus
    initial begin
        logic [25:1] a, last;
        logic [19:0] off;
        logic [11:0] row, rk, r0;
        logic        al, b, two, il, hit;
        int          lat, cb, cnt;
        // Random DRAM traffic over every module size and bank layout.
        for (int c = 0; c < 6; c++) begin
            two = twos[c];
            il = ils[c];
            reset_cfg(szs[c], two, il);
            cb = (szs[c] == 3'h0) ? 9 : (szs[c] <= 3'h2) ? 10 : 11;
            last = 25'h0;
            for (int k = 0; k < 10; k++) begin
                lfsr = step(lfsr);
                a = {5'h00, two && !il && lfsr[15], lfsr[14:0], lfsr[3:0]};
                if (lfsr[6] && k > 0) a = {last[25:5], lfsr[3:0]};
                off = {1'b0, a[19:1]};
                rk = 12'(off >> cb);
                b = two && (il ? rk[0] : a[20]);
                hit = ovld[b] && orow[b] == rk;
                // Hit 1 cycle, closed bank 2, other row open 3 (one precharge cycle first).
                cnt = hit ? 1 : ovld[b] ? 3 : 2;
                ovld[b] = 1'b1;
                orow[b] = rk;
                last = a;
                bus(a, lfsr[5], 1'b1, 1'b1, 2, lat, row, al);
                check(lat, cnt);
                check(dram_cas_n, b ? 2'b01 : 2'b10);
                check({dram_we_n, dbuf_en_n}, {!lfsr[5], 1'b0});
                if (!il) check(dram_addr, 12'(off & ((20'h1 << cb) - 20'h1)));
                if (!il && !hit) check(row, rk);
            end
        end
        // Expansion cycles to each select and strobe kind.
        for (int i = 0; i < 9; i++) begin
            lfsr = step(lfsr);
            dly = lfsr[1:0];
            bus(xa[i], xmw[i][0], xmw[i][1], 1'b1, 2, lat, row, al);
            check(lat, 32'(3 + dly));
            check({al, per_cs_n, ext_ior_n, ext_iow_n, ext_memr_n, ext_memw_n}, {1'b1, xe[i]});
            check(dbuf_en_n, 1'b0);
        end
        // A local-bus cycle gets no ready.
        bus(25'h0000100, 1'b0, 1'b1, 1'b0, 2, lat, row, al);
        check(lat, 32'h0000000C);
        // Idle: exactly two refreshes, row counting up.
        cnt = 0;
        for (int i = 0; i < 3120; i++) begin
            @(negedge sys_clk);
            if (dram_cas_n === 2'b00 && dram_ras_n === 2'b11) begin
                if (cnt == 0) r0 = dram_addr;
                else check(dram_addr, 12'(r0 + 12'h1));
                cnt++;
            end
        end
        check(cnt, 32'h2);
        // Access launched inside a refresh is held off.
        cnt = 0;
        while (dram_cas_n !== 2'b00 && cnt < 1600) begin
            @(negedge sys_clk);
            cnt++;
        end
        check(32'(cnt < 1600), 32'h1);
        bus(25'h0000200, 1'b1, 1'b1, 1'b1, 0, lat, row, al);
        check(32'(lat >= 3 && lat <= 7), 32'h1);
        conclude();
    end
endmodule : tb_top
